// >>> verilog/adcsp_regs.svh
// Constants for the converter serial port: bit positions, counts and reset values.
`ifndef ADCSP_REGS_SVH
`define ADCSP_REGS_SVH
`define ADCSP_CMD_START      3'd7
`define ADCSP_CMD_CH_HI      3'd6
`define ADCSP_CMD_CH_MID     3'd5
`define ADCSP_CMD_CH_LO      3'd4
`define ADCSP_CMD_SGL        3'd3
`define ADCSP_CMD_UNI        3'd2
`define ADCSP_CMD_MODE_HI    3'd1
`define ADCSP_CMD_MODE_LO    3'd0
`define ADCSP_MODE_EXT       2'h3
`define ADCSP_CMD_RESET      8'h00
`define ADCSP_HOLD_EDGE      5'h08
`define ADCSP_MSB_EDGE       5'h0a
`define ADCSP_FRAME_EDGES    5'h12
`define ADCSP_CLK_PERIOD_NS  32'd10
`define ADCSP_INT_CONV_NS    32'd7500
`define ADCSP_INT_CONV_CYC   ((`ADCSP_INT_CONV_NS + `ADCSP_CLK_PERIOD_NS - 32'd1) / `ADCSP_CLK_PERIOD_NS)
`endif

// >>> verilog/adcsp_pkg.sv
// Types shared by the converter serial port design.
package adcsp_pkg;
  typedef enum logic [4:0] {
    ADCSP_IDLE     = 5'h01,
    ADCSP_SHIFT    = 5'h02,
    ADCSP_EXT_CONV = 5'h04,
    ADCSP_INT_CONV = 5'h08,
    ADCSP_READOUT  = 5'h10
  } adcsp_state_t;
endpackage

// >>> verilog/adcsp_core.sv
// Serial port, strobe and conversion sequencing of a multichannel converter, with its command FIFO.
`timescale 1ns/1ps
`include "adcsp_regs.svh"

// Plain FIFO holding accepted control bytes on their way to the analog side.
module adcsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  logic             clk,      // System clock.
  input  logic             reset_n,  // Asynchronous reset, active low.
  input  logic             inValid,  // Write request.
  output logic             inReady,  // Room for a word.
  input  logic [WIDTH-1:0] inData,   // Word written.
  output logic             outValid, // A word is waiting.
  input  logic             outReady, // Reader takes the word.
  output logic [WIDTH-1:0] outData   // Oldest word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  wire              doWrite = inValid & inReady;
  wire              doRead  = outValid & outReady;

  // Depth must be a power of two for the wrapping pointers.
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad
      $error("adcsp_fifo: unsupported WIDTH or DEPTH");
    end
  endgenerate

  // Full when the pointers differ only in the wrap bit.
  assign inReady  = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  // Pointer update.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end
    else
    begin
      if (doWrite) wrPtr_q <= wrPtr_q + 1'b1;
      if (doRead)  rdPtr_q <= rdPtr_q + 1'b1;
    end
  end

  // Storage has no reset; only written words are ever read.
  always_ff @(posedge clk)
  begin
    if (doWrite) mem[wrPtr_q[AW-1:0]] <= inData;
  end
endmodule

// Device-side logic of the converter serial port.
module adcsp_core
  import adcsp_pkg::*;
#(
  parameter int RESULT_BITS     = 14,
  parameter int FIFO_DEPTH      = 8,
  parameter int INT_CONV_CYCLES = `ADCSP_INT_CONV_CYC
) (
  input  logic                   clk,                // System clock, 100 MHz.
  input  logic                   reset_n,            // Asynchronous reset, active low.
  input  logic                   chipSelectN,        // Chip select pin, active low.
  input  logic                   serialClk,          // Serial clock pin from the host.
  input  logic                   serialIn,           // Serial data input pin.
  input  logic                   powerOffN,          // Shutdown pin, active low.
  input  logic [RESULT_BITS-1:0] resultWord,         // Result from the analog side.
  input  logic                   cmdReady,           // Analog side takes a command.
  output logic                   serialOut,          // Serial data output.
  output logic                   serialOutEnN,       // Data output enable, low drives.
  output logic                   conversionStrobe,   // Strobe output.
  output logic                   conversionStrobeEnN,// Strobe enable, low drives.
  output logic                   holdActive,         // Sample held, conversion running.
  output logic                   shutdownActive,     // Device powered down.
  output logic                   channelSelectHi,    // Channel select bit 2.
  output logic                   channelSelectMid,   // Channel select bit 1.
  output logic                   channelSelectLo,    // Channel select bit 0.
  output logic                   singleOrDiffSelect, // 1 single-ended, 0 differential.
  output logic                   polaritySelect,     // 1 unipolar, 0 bipolar.
  output logic                   extClockMode,       // Last byte chose external clock.
  output logic                   cmdValid,           // Command word waiting.
  output logic [7:0]             cmdByte             // Command word for the analog side.
);
  localparam int TW = 16;

  generate
    if (RESULT_BITS < 1 || RESULT_BITS > 16 || INT_CONV_CYCLES < 1 || INT_CONV_CYCLES >= (1 << TW))
    begin : g_bad
      $error("adcsp_core: unsupported parameter value");
    end
  endgenerate

  // Two-stage synchronisers for all pins, plus a history stage for edges.
  logic [1:0]            csSync_q;
  logic [1:0]            clkSync_q;
  logic [1:0]            dinSync_q;
  logic [1:0]            pwrSync_q;
  logic                  clkPrev_q;
  adcsp_state_t          state_q;
  logic [4:0]            fallCnt_q;
  logic [7:0]            shiftIn_q;
  logic [RESULT_BITS-1:0] resultSh_q;
  logic [TW-1:0]         timer_q;
  logic                  fifoInReady;
  logic                  fifoOutValid;
  logic [7:0]            fifoOutData;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      csSync_q  <= 2'h3;
      clkSync_q <= 2'h0;
      dinSync_q <= 2'h0;
      pwrSync_q <= 2'h0;
      clkPrev_q <= 1'b0;
    end
    else
    begin
      csSync_q  <= {csSync_q[0], chipSelectN};
      clkSync_q <= {clkSync_q[0], serialClk};
      dinSync_q <= {dinSync_q[0], serialIn};
      pwrSync_q <= {pwrSync_q[0], powerOffN};
      clkPrev_q <= clkSync_q[1];
    end
  end

  // Synchronised levels and serial clock edges.
  wire csHigh    = csSync_q[1];
  wire dinS      = dinSync_q[1];
  wire powerOn   = pwrSync_q[1];
  wire sclkRise  = clkSync_q[1] & ~clkPrev_q;
  wire sclkFall  = ~clkSync_q[1] & clkPrev_q;
  wire sampleIn  = sclkRise & ~csHigh & powerOn;
  wire fallNext  = sclkFall & ~csHigh & powerOn;
  wire [4:0] fallInc = fallCnt_q + 5'h01;
  wire holdEdge  = (state_q == ADCSP_SHIFT) & fallNext & (fallInc == `ADCSP_HOLD_EDGE);
  wire newExt    = shiftIn_q[`ADCSP_CMD_MODE_HI:`ADCSP_CMD_MODE_LO] == `ADCSP_MODE_EXT;
  wire pushCmd   = holdEdge & fifoInReady;
  wire timerDone = (state_q == ADCSP_INT_CONV) & (timer_q == '0);
  wire resultMsb = resultSh_q[RESULT_BITS-1];
  wire abortSel  = csHigh & (state_q != ADCSP_INT_CONV);

  // Frame sequencer.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q   <= ADCSP_IDLE;
      fallCnt_q <= 5'h00;
      shiftIn_q <= `ADCSP_CMD_RESET;
    end
    else if (!powerOn || abortSel)
    begin
      state_q   <= ADCSP_IDLE;
      fallCnt_q <= 5'h00;
    end
    else
    begin
      if (sampleIn && (state_q == ADCSP_IDLE) && dinS) shiftIn_q <= 8'h01;
      else if (sampleIn && (state_q == ADCSP_SHIFT)) shiftIn_q <= {shiftIn_q[6:0], dinS};
      if (sampleIn && (state_q == ADCSP_IDLE) && dinS) state_q <= ADCSP_SHIFT;
      if (fallNext && (state_q != ADCSP_IDLE) && (fallCnt_q != 5'h1f)) fallCnt_q <= fallInc;
      if (holdEdge) state_q <= !fifoInReady ? ADCSP_IDLE : (newExt ? ADCSP_EXT_CONV : ADCSP_INT_CONV);
      if ((state_q == ADCSP_EXT_CONV) && fallNext && (fallInc == `ADCSP_FRAME_EDGES)) state_q <= ADCSP_READOUT;
      if (timerDone) state_q <= ADCSP_READOUT;
    end
  end

  // Conversion result shifting and internal conversion timer.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      resultSh_q <= '0;
      timer_q    <= '0;
      serialOut  <= 1'b0;
    end
    else if (powerOn)
    begin
      if (pushCmd) resultSh_q <= resultWord;
      if (pushCmd) timer_q <= TW'(INT_CONV_CYCLES - 1);
      else if ((state_q == ADCSP_INT_CONV) && (timer_q != '0)) timer_q <= timer_q - 1'b1;
      if (fallNext && (((state_q == ADCSP_EXT_CONV) && (fallInc >= `ADCSP_MSB_EDGE))
                       || ((state_q == ADCSP_READOUT) && (extClockMode || fallCnt_q >= `ADCSP_HOLD_EDGE))))
      begin
        serialOut  <= resultMsb;
        resultSh_q <= {resultSh_q[RESULT_BITS-2:0], 1'b0};
      end
    end
  end

  // Output enables, strobe, hold and decoded command fields.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      serialOutEnN        <= 1'b1;
      conversionStrobe    <= 1'b1;
      conversionStrobeEnN <= 1'b1;
      holdActive          <= 1'b0;
      shutdownActive      <= 1'b0;
      extClockMode        <= 1'b0;
      {channelSelectHi, channelSelectMid, channelSelectLo} <= 3'h0;
      singleOrDiffSelect  <= 1'b0;
      polaritySelect      <= 1'b0;
    end
    else
    begin
      serialOutEnN   <= csHigh;
      shutdownActive <= ~powerOn;
      conversionStrobeEnN <= csHigh & extClockMode;
      if (!powerOn || abortSel)
      begin
        holdActive       <= 1'b0;
        conversionStrobe <= ~extClockMode;
      end
      else if (pushCmd)
      begin
        holdActive   <= 1'b1;
        extClockMode <= newExt;
        channelSelectHi    <= shiftIn_q[`ADCSP_CMD_CH_HI];
        channelSelectMid   <= shiftIn_q[`ADCSP_CMD_CH_MID];
        channelSelectLo    <= shiftIn_q[`ADCSP_CMD_CH_LO];
        singleOrDiffSelect <= shiftIn_q[`ADCSP_CMD_SGL];
        polaritySelect     <= shiftIn_q[`ADCSP_CMD_UNI];
        conversionStrobe   <= newExt;
      end
      else
      begin
        if ((state_q == ADCSP_EXT_CONV) && fallNext && (fallInc == `ADCSP_MSB_EDGE)) conversionStrobe <= 1'b0;
        if ((state_q == ADCSP_EXT_CONV) && fallNext && (fallInc == `ADCSP_FRAME_EDGES)) holdActive <= 1'b0;
        if (timerDone)
        begin
          conversionStrobe <= 1'b1;
          holdActive       <= 1'b0;
        end
      end
    end
  end

  adcsp_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .inValid  (holdEdge),
    .inReady  (fifoInReady),
    .inData   (shiftIn_q),
    .outValid (fifoOutValid),
    .outReady (~cmdValid | cmdReady),
    .outData  (fifoOutData)
  );

  // Registered output stage of the command stream.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmdValid <= 1'b0;
      cmdByte  <= `ADCSP_CMD_RESET;
    end
    else if (~cmdValid | cmdReady)
    begin
      cmdValid <= fifoOutValid;
      if (fifoOutValid) cmdByte <= fifoOutData;
    end
  end

  // Checks on the device behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_dout_float: assert property (csHigh |=> serialOutEnN) else $error("data output driven while deselected");
  a_strb_float: assert property (csHigh && extClockMode |=> conversionStrobeEnN)
    else $error("strobe driven while deselected in external mode");
  a_dout_fall: assert property (!$stable(serialOut) |-> $past(sclkFall)) else $error("data changed off falling edge");
  a_no_capture: assert property (!sampleIn |=> $stable(shiftIn_q)) else $error("input captured while deselected");
  a_start_bit: assert property ($rose(state_q == ADCSP_SHIFT) |-> shiftIn_q == 8'h01) else $error("bad start bit");
  a_hold_edge: assert property (holdEdge && fifoInReady |=> holdActive && fallCnt_q == 5'h08)
    else $error("hold not on eighth falling edge");
  a_int_strobe: assert property ($rose(state_q == ADCSP_INT_CONV) |-> !conversionStrobe ##1 !conversionStrobe)
    else $error("internal strobe not low at conversion start");
  a_int_done: assert property (timerDone |=> conversionStrobe && !holdActive) else $error("strobe not high at done");
  a_ext_strobe: assert property (conversionStrobe && state_q == ADCSP_EXT_CONV |-> fallCnt_q inside {5'h08, 5'h09})
    else $error("external strobe outside two periods");
  a_ext_pace: assert property (state_q == ADCSP_EXT_CONV && powerOn && !csHigh && !sclkFall
    |=> $stable(fallCnt_q)) else $error("conversion stepped without serial clock");
  a_frame_len: assert property ($fell(holdActive) && extClockMode && powerOn && !csHigh |-> fallCnt_q == 5'h12)
    else $error("external conversion not 18 cycles");
  a_shutdown: assert property (!powerOn |=> state_q == ADCSP_IDLE && shutdownActive) else $error("no shutdown");
  a_decode_ch: assert property (pushCmd |=> channelSelectHi == $past(shiftIn_q[6]) && polaritySelect == $past(shiftIn_q[2]))
    else $error("control byte fields misdecoded");

  c_ext_frame: cover property (state_q == ADCSP_EXT_CONV ##[1:1000] state_q == ADCSP_READOUT);
  c_int_frame: cover property (timerDone);
  c_refused:   cover property (holdEdge && !fifoInReady);
endmodule

// >>> test/adcsp_host_model.sv
// Host-side model that clocks control bytes in and result bits out of the converter port.
`timescale 1ns/1ps
module adcsp_host_model (
  input  wire logic clk,                 // System clock that paces the link.
  input  wire logic serialOut,           // Data output of the device.
  input  wire logic serialOutEnN,        // Data output enable, low drives.
  input  wire logic conversionStrobe,    // Strobe output of the device.
  input  wire logic conversionStrobeEnN, // Strobe enable, low drives.
  output logic      chipSelectN,         // Chip select, active low.
  output logic      serialClk,           // Link clock, low whenever no bit is being sent.
  output logic      serialIn             // Data towards the device.
);
  logic [63:0] doutBits; // Data pin level at each rising link edge.
  logic [63:0] strbBits; // Strobe pin level at each rising link edge.
  int          rises;    // Rising link edges in the current frame.

  // A released pin has no pull resistor, so it shows the inverse of the driven level.
  wire logic doutPin = serialOutEnN ? ~serialOut : serialOut;
  wire logic strbPin = conversionStrobeEnN ? ~conversionStrobe : conversionStrobe;

  // Idle link at time zero: deselected, clock low.
  initial
  begin
    chipSelectN = 1'b1;
    serialClk   = 1'b0;
    serialIn    = 1'b0;
    rises       = 0;
  end

  task automatic start();
    @(posedge clk);
    chipSelectN <= 1'b0;
    rises = 0;
    repeat (10) @(posedge clk);
  endtask

  // Deselects; the released data line shows the inverse of its last level.
  task automatic stop();
    repeat (10) @(posedge clk);
    chipSelectN <= 1'b1;
    serialIn    <= ~serialIn;
    repeat (10) @(posedge clk);
  endtask

  // duty near half
  // Sends n bits MSB first, sampling both output pins at each rising link edge.
  task automatic clocks(input int n, input logic [31:0] bits);
    for (int i = n - 1; i >= 0; i--)
    begin
      serialIn <= bits[i];
      repeat (6 + (rises & 1)) @(posedge clk);
      serialClk <= 1'b1;
      rises++;
      doutBits[rises] = doutPin;
      strbBits[rises] = strbPin;
      repeat (6) @(posedge clk);
      serialClk <= 1'b0;
    end
  endtask
endmodule

// >>> test/adc_serial_port_strobe_tb.sv
// Self-checking testbench of the converter serial port against a host model.
`timescale 1ns/1ps
module adc_serial_port_strobe_tb;
  logic        clk = 1'b0;           // System clock, 100 MHz.
  logic        reset_n = 1'b0;       // Reset, active low.
  logic        powerOffN = 1'b1;     // Shutdown pin, active low.
  logic [13:0] resultWord = 14'h0;   // Result from the analog side.
  logic        cmdReady = 1'b1;      // Downstream takes commands.
  logic        chipSelectN, serialClk, serialIn, serialOut, serialOutEnN, conversionStrobe;
  logic        conversionStrobeEnN, holdActive, shutdownActive, cmdValid, extClockMode;
  logic        channelSelectHi, channelSelectMid, channelSelectLo, singleOrDiffSelect, polaritySelect;
  logic [7:0]  cmdByte;
  logic [7:0]  expQ[$];              // Bytes expected on the command stream.
  int          errors = 0;
  int          nChecks = 0;
  int          seed = 18691;

  always #5 clk = ~clk;

  adcsp_core #(.INT_CONV_CYCLES(20)) i_dut (
    .clk(clk), .reset_n(reset_n), .chipSelectN(chipSelectN), .serialClk(serialClk), .serialIn(serialIn),
    .powerOffN(powerOffN), .resultWord(resultWord), .cmdReady(cmdReady), .serialOut(serialOut),
    .serialOutEnN(serialOutEnN), .conversionStrobe(conversionStrobe), .conversionStrobeEnN(conversionStrobeEnN),
    .holdActive(holdActive), .shutdownActive(shutdownActive), .channelSelectHi(channelSelectHi),
    .channelSelectMid(channelSelectMid), .channelSelectLo(channelSelectLo),
    .singleOrDiffSelect(singleOrDiffSelect), .polaritySelect(polaritySelect), .extClockMode(extClockMode),
    .cmdValid(cmdValid), .cmdByte(cmdByte));

  adcsp_host_model i_host (
    .clk(clk), .serialOut(serialOut), .serialOutEnN(serialOutEnN), .conversionStrobe(conversionStrobe),
    .conversionStrobeEnN(conversionStrobeEnN), .chipSelectN(chipSelectN), .serialClk(serialClk),
    .serialIn(serialIn));

  // Compares one value and counts the outcome.
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    nChecks++;
    if (seen !== want)
    begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Compares the result bits read back, MSB first, from the given rising edge on.
  task automatic checkResult(input int first);
    for (int k = 0; k < 14; k++)
      check(16'(i_host.doutBits[first + k]), 16'(resultWord[13 - k]), "result bit");
  endtask

  // Sends one bare control byte and checks the decoded fields.
  task automatic shortFrame(input logic [7:0] b, input logic accept);
    i_host.start();
    if (accept)
      expQ.push_back(b);
    i_host.clocks(8, 32'(b));
    repeat (6) @(posedge clk);
    check(16'(holdActive), 16'(accept), "hold taken");
    if (accept)
      check(16'({channelSelectHi, channelSelectMid, channelSelectLo, singleOrDiffSelect, polaritySelect,
                 extClockMode}), 16'({b[6:2], &b[1:0]}), "fields");
    i_host.stop();
  endtask

  // Takes each accepted command off the queue and compares it.
  always @(posedge clk)
    if (cmdValid === 1'b1 && cmdReady === 1'b1)
    begin
      if (expQ.size() == 0)
        check(16'(cmdByte), 16'hffff, "unexpected command");
      else
        check(16'(cmdByte), 16'(expQ.pop_front()), "command byte");
    end

  // Cuts a hung run short.
  initial
  begin
    #200us;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end

  // Main sequence.
  initial
  begin
    logic [7:0] b;
    int         i;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    check(16'({serialOutEnN, conversionStrobeEnN, cmdValid}), 16'h4, "idle enables");
    // External clock frame led by three zero bits.
    b = {1'b1, 5'($random(seed)), 2'b11};
    resultWord <= 14'($random(seed));
    i_host.start();
    expQ.push_back(b);
    i_host.clocks(11, 32'(b));
    repeat (6) @(posedge clk);
    check(16'(holdActive), 16'h1, "hold ext");
    check(16'({channelSelectHi, channelSelectMid, channelSelectLo, singleOrDiffSelect, polaritySelect}),
          16'(b[6:2]), "fields ext");
    i_host.clocks(16, 32'h0);
    for (i = 12; i < 16; i++)
      check(16'(i_host.strbBits[i]), 16'(i < 14), "ext strobe");
    checkResult(14);
    check(16'(holdActive), 16'h0, "hold end ext");
    i_host.stop();
    check(16'({serialOutEnN, conversionStrobeEnN}), 16'h3, "float on deselect");
    $display("test external frame done");
    // Internal clock frame.
    b = {1'b1, 5'($random(seed)), 2'b01};
    resultWord <= 14'($random(seed));
    i_host.start();
    expQ.push_back(b);
    i_host.clocks(8, 32'(b));
    repeat (8) @(posedge clk);
    check(16'(conversionStrobe), 16'h0, "strobe low busy");
    for (i = 0; i < 100 && conversionStrobe !== 1'b1; i++)
      @(posedge clk);
    check(16'({conversionStrobe, holdActive}), 16'h2, "strobe high done");
    i_host.clocks(15, 32'h0);
    checkResult(10);
    i_host.stop();
    $display("test internal frame done");
    // Link clocked while deselected captures nothing.
    i_host.clocks(8, 32'hff);
    repeat (8) @(posedge clk);
    check(16'({holdActive, cmdValid}), 16'h0, "deselected");
    $display("test deselected clocks done");
    // Shutdown refuses frames.
    powerOffN <= 1'b0;
    repeat (6) @(posedge clk);
    check(16'(shutdownActive), 16'h1, "shutdown on");
    shortFrame(8'hff, 1'b0);
    powerOffN <= 1'b1;
    repeat (6) @(posedge clk);
    check(16'(shutdownActive), 16'h0, "shutdown off");
    $display("test shutdown done");
    // Fill the command buffer while stalled, then drain it.
    cmdReady <= 1'b0;
    // Eight buffer words plus the registered output word are taken before a refusal.
    for (i = 0; i < 9; i++)
      shortFrame({1'b1, 7'($random(seed))}, 1'b1);
    shortFrame(8'hff, 1'b0);
    for (i = 0; i < 400 && expQ.size() > 0; i++)
      @(posedge clk) cmdReady <= 1'($random(seed));
    @(posedge clk) cmdReady <= 1'b1;
    repeat (4) @(posedge clk);
    check(16'({expQ.size() == 0, cmdValid}), 16'h2, "drained");
    $display("test command buffer done");
    conclude();
  end
endmodule
